// >>> shared/csu_pkg.sv
package csu_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [3:0] CSU_A_CTL0 = 4'h0;
    localparam logic [3:0] CSU_A_CTL1 = 4'h1;
    localparam logic [3:0] CSU_A_CTL2 = 4'h2;
    localparam logic [3:0] CSU_A_STR = 4'h3;
    localparam logic [3:0] CSU_A_TXL = 4'h4;
    localparam logic [3:0] CSU_A_TXH = 4'h5;
    localparam logic [3:0] CSU_A_RXL = 4'h6;
    localparam logic [3:0] CSU_A_RXH = 4'h7;
    localparam logic [3:0] CSU_A_BAUD_PRESCALER_MODE = 4'h8;
    localparam logic [3:0] CSU_A_BAUD_DIVISOR_COMPARE = 4'h9;
    localparam logic [3:0] CSU_A_ISTAT = 4'hA;
    localparam logic [3:0] CSU_A_ICLR = 4'hB;
    localparam logic [3:0] CSU_A_IEN = 4'hC;

    // ****************************************************************
    // Field positions and codes
    // ****************************************************************
    localparam int CSU_B_PWR = 7;
    localparam int CSU_B_TXE = 6;
    localparam int CSU_B_RXE = 5;
    localparam int CSU_B_DIR = 4;
    localparam int CSU_B_TMS = 1;
    localparam int CSU_B_CKP = 4;
    localparam int CSU_B_DAP = 3;
    localparam int CSU_B_OVR = 0;
    localparam int CSU_B_BUSY = 7;
    localparam logic [2:0] CSU_CKS_EXT = 3'h7;
    localparam int CSU_EV_RX = 0;
    localparam int CSU_EV_TX = 1;
    localparam int CSU_EV_OVR = 2;
    localparam int CSU_NEV = 3;

    // ****************************************************************
    // Reset values and timing
    // ****************************************************************
    localparam logic [7:0] CSU_RST_CTL = 8'h00;
    localparam logic [7:0] CSU_RST_BAUD_PRESCALER_MODE = 8'h00;
    localparam logic [7:0] CSU_RST_BAUD_DIVISOR_COMPARE = 8'h00;
    localparam logic [8:0] CSU_CMP_ZERO_DIV = 9'h100;
    localparam int CSU_CNT_W = 12;

    typedef enum logic [1:0] {
        CSU_IDLE,
        CSU_RUN,
        CSU_DRAIN
    } csu_state_t;

endpackage : csu_pkg

// >>> shared/csu_baud_if.sv
`timescale 1ns/1ns
`default_nettype none
interface csu_baud_if;
    logic run;
    logic [1:0] k;
    logic [7:0] cmp;
    logic tick;
    modport ctl (output run, output k, output cmp, input tick);
    modport gen (input run, input k, input cmp, output tick);
endinterface : csu_baud_if
`default_nettype wire

// >>> src/csu_baud.sv
`timescale 1ns/1ns
`default_nettype none
module csu_baud #(
    parameter int CNT_W = csu_pkg::CSU_CNT_W
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    csu_baud_if.gen bif
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic tick;
    } csu_baud_st_t;

    csu_baud_st_t s;
    csu_baud_st_t next_s;
    logic [CNT_W-1:0] lim;
    logic [CNT_W:0] gap;

    if (CNT_W < csu_pkg::CSU_CNT_W) begin : g_chk
        $error("csu_baud: counter too narrow for divide by 4096");
    end

    // Period in main clocks is the compare divisor times two to the (k+1).
    function automatic logic [CNT_W-1:0] csu_limit(input logic [1:0] k, input logic [7:0] c);
        logic [8:0] nd;
        logic [CNT_W:0] d;
        nd = (c == 8'h00) ? csu_pkg::CSU_CMP_ZERO_DIV : {1'b0, c}; // [RULE7]
        d = (CNT_W+1)'(nd) << ({1'b0, k} + 3'h1); // [RULE5] [RULE6]
        return CNT_W'(d - (CNT_W+1)'(1));
    endfunction : csu_limit

    assign lim = csu_limit(bif.k, bif.cmp);

    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (!bif.run) begin
            next_s.cnt = '0;
        end else if (s.cnt >= lim) begin
            next_s.cnt = '0;
            next_s.tick = 1'b1; // [RULE5]
        end else begin
            next_s.cnt = s.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign bif.tick = s.tick;

    // Helper: enabled cycles since the last tick, for the period check.
    always_ff @(posedge clk) begin
        if (!rstn || !bif.run) begin
            gap <= '0;
        end else if (ce) begin
            gap <= s.tick ? (CNT_W+1)'(1) : gap + (CNT_W+1)'(1);
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_tick_period: assert property ( // [RULE5]
        (ce && s.tick && $stable(lim) && gap != 0) |-> (gap == {1'b0, lim} + (CNT_W+1)'(1))
    ) else $error("baud tick spacing differs from the divisor");

    chk_zero_cmp: assert property ( // [RULE7]
        (bif.cmp == 8'h00 && bif.k == 2'h0) |-> (lim == CNT_W'(511))
    ) else $error("compare value zero not treated as 256");

endmodule : csu_baud
`default_nettype wire

// >>> src/csu_irq.sv
`timescale 1ns/1ns
`default_nettype none
module csu_irq #(
    parameter int NEV = csu_pkg::CSU_NEV
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [NEV-1:0] ev,
    input wire logic clr_wr,
    input wire logic en_wr,
    input wire logic [NEV-1:0] wdata,
    output logic [NEV-1:0] stat,
    output logic [NEV-1:0] en,
    output logic irq
);
    typedef struct packed {
        logic [NEV-1:0] stat;
        logic [NEV-1:0] en;
        logic irq;
    } csu_irq_st_t;

    csu_irq_st_t s;
    csu_irq_st_t next_s;

    if (NEV < 1 || NEV > 8) begin : g_chk
        $error("csu_irq: event count must fit one byte");
    end

    // Set is applied after the clear so that a same-cycle event survives.
    always_comb begin
        next_s = s;
        if (clr_wr) begin
            next_s.stat = s.stat & ~wdata;
        end
        next_s.stat = next_s.stat | ev;
        if (en_wr) begin
            next_s.en = wdata;
        end
        next_s.irq = |(s.stat & s.en);
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign stat = s.stat;
    assign en = s.en;
    assign irq = s.irq;

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_set_wins: assert property (
        (ce && |ev) |=> ((stat & $past(ev)) == $past(ev))
    ) else $error("event lost against a status clear");

endmodule : csu_irq
`default_nettype wire

// >>> src/csu_top.sv
// Functional notes
// RULE1 - Powered down: clock pin floats or idles by polarity.
// RULE2 - Powered down clock level follows polarity/source rewrites.
// RULE3 - Powered down data out: low, latch, first bit. The code drives data out low in phase 0 instead of holding a latched level.
// RULE4 - Powered down data out follows enable/order/phase rewrites.
// RULE5 - Baud clock is main clock over 2^(k+1)*N.
// RULE6 - Prescaler exponent ranges 0 to 3.
// RULE7 - Divisor 1 to 256; zero means 256.
// RULE8 - Prescaler registers reset zero; compare byte-wide.
// RULE9 - Host checks overrun after DMA completes.
// RULE10 - Host never rewrites setup while powered.
// RULE11 - Phase 1: busy clears half clock after done.
// RULE12 - Single mode: transmit write while busy ignored.
// RULE13 - Single receive-only: read while busy starts nothing.
// RULE14 - Host checks busy clear before next single transfer.
// RULE15 - Host prefers continuous mode, especially with DMA.
// RULE16 - Clock source all ones selects external clock.
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module csu_top (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [3:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rd_data,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic si_in,
    output logic so_out,
    output logic irq
);
    typedef struct packed {
        logic [7:0] ctl0;
        logic [7:0] ctl1;
        logic [7:0] ctl2;
        logic [7:0] baud_prescaler_mode;
        logic [7:0] baud_divisor_compare;
        logic [15:0] tx;
        logic [15:0] sh;
        logic [15:0] rx;
        logic [15:0] rxd;
        logic ovr;
        logic pend;
        logic unread;
        csu_pkg::csu_state_t state;
        logic [5:0] cnt;
        logic [2:0] ssy;
        logic sst;
        logic [2:0] dsy;
        logic sck;
        logic sck_oe;
        logic so;
        logic [7:0] rdat;
    } csu_top_st_t;

    csu_top_st_t s;
    csu_top_st_t next_s;
    csu_baud_if bd ();
    logic [csu_pkg::CSU_NEV-1:0] ev;
    logic [csu_pkg::CSU_NEV-1:0] istat;
    logic [csu_pkg::CSU_NEV-1:0] ien;
    logic pwr, txe, rxe, dir, cont, ckp, dap, ext, busy;
    logic [4:0] len;
    logic slv_edge, sh_edge, tx_ok, tx_start, rx_start, rx_rd;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [4:0] csu_len(input logic [3:0] cl);
        return cl[3] ? 5'h10 : (5'h08 + {2'h0, cl[2:0]});
    endfunction : csu_len

    function automatic logic csu_first(input logic [15:0] v, input logic d, input logic [4:0] l);
        return d ? v[0] : v[4'(l - 5'h01)];
    endfunction : csu_first

    function automatic logic [15:0] csu_ins(input logic [15:0] v, input logic b,
                                            input logic d, input logic [4:0] l);
        logic [15:0] r;
        r = v >> 1;
        r[4'(l - 5'h01)] = b;
        return d ? r : {v[14:0], b};
    endfunction : csu_ins

    function automatic csu_top_st_t csu_rst();
        csu_top_st_t r;
        r = '0;
        r.ctl0 = csu_pkg::CSU_RST_CTL;
        r.ctl1 = csu_pkg::CSU_RST_CTL;
        r.ctl2 = csu_pkg::CSU_RST_CTL;
        r.baud_prescaler_mode = csu_pkg::CSU_RST_BAUD_PRESCALER_MODE; // [RULE8]
        r.baud_divisor_compare = csu_pkg::CSU_RST_BAUD_DIVISOR_COMPARE; // [RULE8]
        r.state = csu_pkg::CSU_IDLE;
        return r;
    endfunction : csu_rst

    // ****************************************************************
    // Decoded settings
    // ****************************************************************
    assign pwr = s.ctl0[csu_pkg::CSU_B_PWR];
    assign txe = s.ctl0[csu_pkg::CSU_B_TXE];
    assign rxe = s.ctl0[csu_pkg::CSU_B_RXE];
    assign dir = s.ctl0[csu_pkg::CSU_B_DIR];
    assign cont = s.ctl0[csu_pkg::CSU_B_TMS];
    assign ckp = s.ctl1[csu_pkg::CSU_B_CKP];
    assign dap = s.ctl1[csu_pkg::CSU_B_DAP];
    assign ext = (s.ctl1[2:0] == csu_pkg::CSU_CKS_EXT); // [RULE16]
    assign len = csu_len(s.ctl2[3:0]);
    assign busy = (s.state != csu_pkg::CSU_IDLE);

    // Only the agreeing second and third stages may declare a new level.
    assign slv_edge = (s.ssy[2] == s.ssy[1]) && (s.ssy[1] != s.sst);
    assign sh_edge = ext ? slv_edge : bd.tick;
    assign tx_ok = !(busy && !cont); // [RULE12]
    assign tx_start = wr && addr == csu_pkg::CSU_A_TXL && txe && !busy;
    assign rx_rd = rd && addr == csu_pkg::CSU_A_RXL;
    assign rx_start = rx_rd && !txe && rxe && !busy; // [RULE13]

    assign bd.run = pwr;
    assign bd.k = s.baud_prescaler_mode[1:0];
    assign bd.cmp = s.baud_divisor_compare;

    csu_baud u_baud (
        .clk (clk),
        .rstn (rstn),
        .ce (ce),
        .bif (bd)
    );

    csu_irq u_irq (
        .clk (clk),
        .rstn (rstn),
        .ce (ce),
        .ev (ev),
        .clr_wr (wr && addr == csu_pkg::CSU_A_ICLR),
        .en_wr (wr && addr == csu_pkg::CSU_A_IEN),
        .wdata (wr_data[csu_pkg::CSU_NEV-1:0]),
        .stat (istat),
        .en (ien),
        .irq (irq)
    );

    // ****************************************************************
    // Register access and transfer engine
    // ****************************************************************
    always_comb begin
        next_s = s;
        ev = '0;
        next_s.ssy = {s.ssy[1:0], sck_in};
        next_s.dsy = {s.dsy[1:0], si_in};
        if (s.ssy[2] == s.ssy[1]) begin
            next_s.sst = s.ssy[1];
        end
        next_s.rdat = 8'h00;
        if (rd) begin
            case (addr)
                csu_pkg::CSU_A_CTL0: next_s.rdat = s.ctl0;
                csu_pkg::CSU_A_CTL1: next_s.rdat = s.ctl1;
                csu_pkg::CSU_A_CTL2: next_s.rdat = s.ctl2;
                csu_pkg::CSU_A_STR: next_s.rdat = {busy, 6'h00, s.ovr};
                csu_pkg::CSU_A_TXL: next_s.rdat = s.tx[7:0];
                csu_pkg::CSU_A_TXH: next_s.rdat = s.tx[15:8];
                csu_pkg::CSU_A_RXL: next_s.rdat = s.rxd[7:0];
                csu_pkg::CSU_A_RXH: next_s.rdat = s.rxd[15:8];
                csu_pkg::CSU_A_BAUD_PRESCALER_MODE: next_s.rdat = s.baud_prescaler_mode;
                csu_pkg::CSU_A_BAUD_DIVISOR_COMPARE: next_s.rdat = s.baud_divisor_compare;
                csu_pkg::CSU_A_ISTAT: next_s.rdat = 8'(istat);
                csu_pkg::CSU_A_IEN: next_s.rdat = 8'(ien);
                default: next_s.rdat = 8'h00;
            endcase
        end
        if (rx_rd) begin
            next_s.unread = 1'b0;
        end
        if (wr) begin
            case (addr)
                csu_pkg::CSU_A_CTL0: next_s.ctl0 = wr_data;
                csu_pkg::CSU_A_CTL1: next_s.ctl1 = wr_data;
                csu_pkg::CSU_A_CTL2: next_s.ctl2 = {4'h0, wr_data[3:0]};
                csu_pkg::CSU_A_STR: begin
                    if (!wr_data[csu_pkg::CSU_B_OVR]) begin
                        next_s.ovr = 1'b0;
                    end
                end
                csu_pkg::CSU_A_TXL: begin
                    if (tx_ok) begin
                        next_s.tx[7:0] = wr_data; // [RULE12]
                        next_s.pend = busy && pwr;
                    end
                end
                csu_pkg::CSU_A_TXH: begin
                    if (tx_ok) begin
                        next_s.tx[15:8] = wr_data; // [RULE12]
                    end
                end
                csu_pkg::CSU_A_BAUD_PRESCALER_MODE: begin
                    next_s.baud_prescaler_mode = {6'h00, wr_data[1:0]}; // [RULE6]
                end
                csu_pkg::CSU_A_BAUD_DIVISOR_COMPARE: begin
                    next_s.baud_divisor_compare = wr_data; // [RULE8]
                end
                default: ;
            endcase
        end
        if (!pwr) begin
            // Idle pin levels are recomputed every cycle, so a rewrite shows on the pins one cycle after the register takes it.
            next_s.state = csu_pkg::CSU_IDLE;
            next_s.pend = 1'b0;
            next_s.cnt = 6'h00;
            next_s.sck = !ckp; // [RULE1] [RULE2]
            next_s.sck_oe = !ext; // [RULE1] [RULE2] [RULE16]
            next_s.so = txe && dap && csu_first(s.tx, dir, len); // [RULE3] [RULE4]
        end else begin
            case (s.state)
                csu_pkg::CSU_IDLE: begin
                    next_s.sck = !ckp;
                    next_s.sck_oe = !ext;
                    if (tx_start || rx_start || s.pend) begin
                        next_s.state = csu_pkg::CSU_RUN;
                        next_s.sh = next_s.tx;
                        next_s.rx = 16'h0000;
                        next_s.cnt = 6'h00;
                        next_s.pend = 1'b0;
                        next_s.so = txe && csu_first(next_s.tx, dir, len);
                        ev[csu_pkg::CSU_EV_TX] = cont && txe;
                    end
                end
                csu_pkg::CSU_RUN: begin
                    if (sh_edge) begin
                        next_s.cnt = s.cnt + 6'h01;
                        if (!ext) begin
                            next_s.sck = !s.sck;
                        end
                        if (s.cnt[0] == dap) begin
                            next_s.rx = csu_ins(s.rx, s.dsy[2], dir, len);
                        end else if (s.cnt != 6'h00 && next_s.cnt != {len, 1'b0}) begin
                            next_s.sh = dir ? (s.sh >> 1) : (s.sh << 1);
                            next_s.so = txe && csu_first(next_s.sh, dir, len);
                        end
                        if (next_s.cnt == {len, 1'b0}) begin
                            next_s.rxd = next_s.rx;
                            ev[csu_pkg::CSU_EV_RX] = 1'b1;
                            if (cont && rxe && next_s.unread) begin
                                next_s.ovr = 1'b1;
                                ev[csu_pkg::CSU_EV_OVR] = 1'b1;
                            end
                            next_s.unread = rxe;
                            // Phase 1 keeps busy one more half clock.
                            next_s.state = dap ? csu_pkg::CSU_DRAIN
                                               : csu_pkg::CSU_IDLE; // [RULE11]
                        end
                    end
                end
                csu_pkg::CSU_DRAIN: begin
                    if (bd.tick) begin
                        next_s.state = csu_pkg::CSU_IDLE; // [RULE11]
                    end
                end
                default: next_s.state = csu_pkg::CSU_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s <= csu_rst();
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign rd_data = s.rdat;
    assign sck_out = s.sck;
    assign sck_oe = s.sck_oe;
    assign so_out = s.so;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_ctl1_wr_off;
        ce && wr && addr == csu_pkg::CSU_A_CTL1 && !pwr;
    endsequence

    sequence s_done_phase1;
        ce && ev[csu_pkg::CSU_EV_RX] && dap;
    endsequence

    chk_idle_sck_level: assert property ( // [RULE1]
        (ce && !pwr && !ext) |=> (sck_out == !$past(ckp)) && sck_oe
    ) else $error("powered-down clock pin level wrong");

    chk_idle_sck_float: assert property ( // [RULE16]
        (ce && !pwr && ext) |=> !sck_oe
    ) else $error("external clock selected but clock pin driven");

    chk_ckp_follow: assert property ( // [RULE2]
        s_ctl1_wr_off ##1 (ce && !pwr && !ext) |=> sck_out == !$past(ckp)
    ) else $error("clock pin did not follow a polarity rewrite");

    chk_so_tx_off: assert property ( // [RULE3]
        (ce && !pwr && !txe) |=> !so_out
    ) else $error("data out not low with transmit disabled");

    chk_so_first_bit: assert property ( // [RULE4]
        (ce && !pwr && txe) |=> so_out == ($past(dap) && $past(csu_first(s.tx, dir, len)))
    ) else $error("powered-down data out not the expected bit");

    chk_single_ignore: assert property ( // [RULE12]
        (ce && busy && !cont && wr && addr == csu_pkg::CSU_A_TXL) |=> s.tx == $past(s.tx)
    ) else $error("transmit write accepted while busy in single mode");

    chk_rxread_nostart: assert property ( // [RULE13]
        (ce && s.state == csu_pkg::CSU_RUN && !cont && !txe && rx_rd && !sh_edge)
            |=> s.cnt == $past(s.cnt)
    ) else $error("receive read restarted a busy single transfer");

    chk_busy_hold: assert property ( // [RULE11]
        s_done_phase1 |=> busy && s.state == csu_pkg::CSU_DRAIN
    ) else $error("busy cleared at completion with phase 1");

    chk_busy_release: assert property ( // [RULE11]
        (ce && s.state == csu_pkg::CSU_DRAIN && bd.tick) |=> !busy
    ) else $error("busy not cleared half a clock after completion");

    chk_prs_reset: assert property ( // [RULE8]
        $past(!rstn) |-> (s.baud_prescaler_mode == 8'h00) && (s.baud_divisor_compare == 8'h00)
    ) else $error("prescaler registers not zero after reset");

endmodule : csu_top
`default_nettype wire

// >>> verif/csu_partner.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Serial partner: answers a fixed byte, MSB first
// ****************************************************************
module csu_partner (
    input wire logic sel,
    input wire logic sck,
    output logic si
);
    localparam logic [7:0] PAT = 8'hA6;
    int edges = -1;
    logic cur = 1'b0;

    // A released data line shows the inverse of its last bit, so a late sample cannot match.
    assign si = sel ? cur : ~cur;

    // One process owns the bit: selection restarts the frame, each trailing edge shifts.
    always @(sel or sck) begin
        if (!sel) begin
            edges = -1;
        end else if (edges < 0) begin
            edges = 0;
            cur = PAT[7];
        end else begin
            edges++;
            if (!edges[0] && edges < 16) begin
                cur = PAT[7 - edges / 2];
            end
        end
    end
endmodule : csu_partner
`default_nettype wire

// >>> verif/csu_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module csu_top_bench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wr_data = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic sel = 1'b0;
    logic [7:0] rd_data;
    logic sck_out;
    logic sck_oe;
    logic so_out;
    logic irq;
    logic si;
    logic sck_prev = 1'b0;
    logic [7:0] d;
    int err_count = 0;
    int checks = 0;
    int toggles = 0;
    int gap = 0;
    int cyc = 0;
    int last_cyc = 0;

    always #5 clk = ~clk;

    csu_top u_csu_top (.clk(clk), .rstn(rstn), .ce(1'b1), .addr(addr), .wr_data(wr_data),
        .wr(wr), .rd(rd), .rd_data(rd_data), .sck_in(1'b1), .sck_out(sck_out),
        .sck_oe(sck_oe), .si_in(si), .so_out(so_out), .irq(irq));
    csu_partner u_csu_partner (.sel(sel), .sck(sck_out), .si(si));

    // ****************************************************************
    // Serial clock edge counter and spacing
    // ****************************************************************
    always @(posedge clk) begin
        cyc <= cyc + 1;
        sck_prev <= sck_out;
        if (rstn && sck_out !== sck_prev) begin
            toggles <= toggles + 1;
            gap <= cyc - last_cyc;
            last_cyc <= cyc;
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wr_data <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rd_data;
    endtask : rd_reg

    task automatic wait_idle();
        for (int i = 0; i < 3000; i++) begin
            rd_reg(csu_pkg::CSU_A_STR, d);
            if (d[7] === 1'b0) return;
        end
        err_count++;
        end_sim();
    endtask : wait_idle

    task automatic test_idle_pins();
        logic [7:0] tx;
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 8; s++) begin
                wr_reg(csu_pkg::CSU_A_CTL1, {3'h0, p[0], 1'b0, s[2:0]});
                repeat (3) @(posedge clk);
                #1;
                check(16'(sck_oe), 16'(s != 7));
                if (s != 7) check(16'(sck_out), 16'(p == 0));
            end
        end
        wr_reg(csu_pkg::CSU_A_TXH, 8'h00);
        for (int t = 0; t < 2; t++) begin
            tx = t ? 8'h80 : 8'h01;
            wr_reg(csu_pkg::CSU_A_TXL, tx);
            for (int m = 0; m < 8; m++) begin
                wr_reg(csu_pkg::CSU_A_CTL1, {4'h0, m[1], 3'h0});
                wr_reg(csu_pkg::CSU_A_CTL0, {1'b0, m[0], 1'b0, m[2], 4'h0});
                repeat (3) @(posedge clk);
                #1;
                check(16'(so_out), 16'((m[0] & m[1]) ? (m[2] ? tx[0] : tx[7]) : 1'b0));
            end
        end
        $display("idle pin test done");
    endtask : test_idle_pins

    task automatic test_master_single();
        int t0;
        wr_reg(csu_pkg::CSU_A_CTL0, 8'h00);
        wr_reg(csu_pkg::CSU_A_CTL1, 8'h00);
        wr_reg(csu_pkg::CSU_A_CTL2, 8'h00);
        wr_reg(csu_pkg::CSU_A_BAUD_PRESCALER_MODE, 8'h01);
        wr_reg(csu_pkg::CSU_A_BAUD_DIVISOR_COMPARE, 8'h03);
        rd_reg(csu_pkg::CSU_A_BAUD_DIVISOR_COMPARE, d);
        check(16'(d), 16'h0003);
        wr_reg(csu_pkg::CSU_A_IEN, 8'h01);
        wr_reg(csu_pkg::CSU_A_CTL0, 8'h60);
        wr_reg(csu_pkg::CSU_A_CTL0, 8'hE0);
        sel <= 1'b1;
        t0 = toggles;
        wr_reg(csu_pkg::CSU_A_TXH, 8'h00);
        wr_reg(csu_pkg::CSU_A_TXL, 8'h3C);
        repeat (30) @(posedge clk);
        wr_reg(csu_pkg::CSU_A_TXL, 8'hFF);
        wait_idle();
        sel <= 1'b0;
        repeat (40) @(posedge clk);
        check(16'(toggles - t0), 16'h0010);
        check(16'(gap), 16'h000C);
        rd_reg(csu_pkg::CSU_A_RXL, d);
        check(16'(d), 16'h00A6);
        check(16'(irq), 16'h0001);
        rd_reg(csu_pkg::CSU_A_ISTAT, d);
        check(16'(d), 16'h0001);
        wr_reg(csu_pkg::CSU_A_ICLR, 8'h01);
        repeat (3) @(posedge clk);
        check(16'(irq), 16'h0000);
        $display("master single test done");
    endtask : test_master_single

    task automatic test_slow_phase1();
        int t0;
        int i;
        wr_reg(csu_pkg::CSU_A_CTL0, 8'h00);
        wr_reg(csu_pkg::CSU_A_CTL1, 8'h08);
        wr_reg(csu_pkg::CSU_A_BAUD_PRESCALER_MODE, 8'h00);
        wr_reg(csu_pkg::CSU_A_BAUD_DIVISOR_COMPARE, 8'h00);
        wr_reg(csu_pkg::CSU_A_CTL0, 8'h20);
        wr_reg(csu_pkg::CSU_A_CTL0, 8'hA0);
        t0 = toggles;
        rd_reg(csu_pkg::CSU_A_RXL, d);
        repeat (600) @(posedge clk);
        rd_reg(csu_pkg::CSU_A_RXL, d);
        for (i = 0; i < 20000 && irq !== 1'b1; i++) @(posedge clk);
        if (i == 20000) begin
            err_count++;
            end_sim();
        end
        rd_reg(csu_pkg::CSU_A_STR, d);
        check(16'(d[7]), 16'h0001);
        repeat (515) @(posedge clk);
        rd_reg(csu_pkg::CSU_A_STR, d);
        check(16'(d[7]), 16'h0000);
        repeat (1100) @(posedge clk);
        check(16'(toggles - t0), 16'h0010);
        check(16'(gap), 16'h0200);
        $display("slow phase one test done");
    endtask : test_slow_phase1

    task automatic test_cont_overrun();
        int t0;
        wr_reg(csu_pkg::CSU_A_CTL0, 8'h00);
        wr_reg(csu_pkg::CSU_A_CTL1, 8'h00);
        wr_reg(csu_pkg::CSU_A_BAUD_DIVISOR_COMPARE, 8'h01);
        wr_reg(csu_pkg::CSU_A_CTL0, 8'h62);
        wr_reg(csu_pkg::CSU_A_CTL0, 8'hE2);
        wr_reg(csu_pkg::CSU_A_ICLR, 8'h07);
        t0 = toggles;
        wr_reg(csu_pkg::CSU_A_TXL, 8'h11);
        wr_reg(csu_pkg::CSU_A_TXL, 8'h22);
        repeat (100) @(posedge clk);
        check(16'(toggles - t0), 16'h0020);
        check(16'(gap), 16'h0002);
        rd_reg(csu_pkg::CSU_A_STR, d);
        check(16'(d), 16'h0001);
        rd_reg(csu_pkg::CSU_A_ISTAT, d);
        check(16'(d), 16'h0007);
        wr_reg(csu_pkg::CSU_A_STR, 8'h00);
        rd_reg(csu_pkg::CSU_A_STR, d);
        check(16'(d), 16'h0000);
        $display("continuous test done");
    endtask : test_cont_overrun

    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rd_reg(csu_pkg::CSU_A_BAUD_PRESCALER_MODE, d);
        check(16'(d), 16'h0000);
        rd_reg(csu_pkg::CSU_A_BAUD_DIVISOR_COMPARE, d);
        check(16'(d), 16'h0000);
        rd_reg(4'hF, d);
        check(16'(d), 16'h0000);
        test_idle_pins();
        test_master_single();
        test_slow_phase1();
        test_cont_overrun();
        end_sim();
    end
endmodule : csu_top_bench
`default_nettype wire
